// ==== core/cpcm_pkg.sv ====
// Constants, field layouts and carrier types for the coprocessor control move unit.
// Assumes one core clock; instruction words arrive already fetched with their operand.
// What this block does
// RULE_01: Pass 25-bit function field to second coprocessor unchanged
// RULE_02: Second coprocessor leaves processor state untouched
// RULE_03: Write source low word into selected fp control register
// RULE_04: Selector 25 updates condition-code bits only
// RULE_05: Selector 26 writes cause and flag fields
// RULE_06: Selector 28 writes enables, flush and rounding
// RULE_07: Selector 31 replaces whole status word
// RULE_08: Cause with enable set raises fp exception
// RULE_09: Return address is the move instruction itself
// RULE_10: Software uses only selectors 25, 26, 28, 31
// RULE_11: Second coprocessor move delivers word and 16-bit selector
// RULE_12: Unusable coprocessor aborts and raises unusable exception
package cpcm_pkg;
    localparam logic [5:0] CPCM_OP_FP = 6'h11;
    localparam logic [5:0] CPCM_OP_CP2 = 6'h12;
    localparam logic [4:0] CPCM_SUB_CT = 5'h06;
    localparam logic [4:0] CPCM_SUB_CF = 5'h02;
    localparam logic [4:0] CPCM_SEL_CC = 5'h19;
    localparam logic [4:0] CPCM_SEL_EX = 5'h1A;
    localparam logic [4:0] CPCM_SEL_EN = 5'h1C;
    localparam logic [4:0] CPCM_SEL_CS = 5'h1F;
    localparam logic [31:0] CPCM_FPSW_RESET = 32'h0000_0000;
    localparam logic [1:0] CPCM_UNIT_FP = 2'h1;
    localparam logic [1:0] CPCM_UNIT_CP2 = 2'h2;
    // AHB register byte addresses
    localparam logic [7:0] CPCM_A_STATUS = 8'h00;
    localparam logic [7:0] CPCM_A_MASK = 8'h04;
    localparam logic [7:0] CPCM_A_ENABLE = 8'h08;
    localparam logic [7:0] CPCM_A_FPSW = 8'h0C;
    localparam logic [7:0] CPCM_A_RETPC = 8'h10;
    // Interrupt status bits
    localparam int CPCM_EV_FPE = 0;
    localparam int CPCM_EV_CPU = 1;
    localparam int CPCM_EV_CP2 = 2;
    localparam int CPCM_EV_W = 3;

    typedef struct packed {
        logic valid;
        logic [31:0] word;
        logic [31:0] pc;
        logic [31:0] gpr;
    } cpcm_instr_type;

    typedef struct packed {
        logic ct_valid;
        logic cf_valid;
        logic op_valid;
        logic [15:0] sel;
        logic [24:0] cofun;
        logic [31:0] data;
    } cpcm_cp2_type;

    typedef struct packed {
        logic valid;
        logic fp_exc;
        logic unusable;
        logic [1:0] unit;
        logic [31:0] return_pc;
    } cpcm_exc_type;
endpackage

// ==== core/cpcm_unit.sv ====
// Coprocessor control move unit: fp control writes, second coprocessor moves.
// Assumes instr is one-cycle valid from the pipeline; AHB-Lite slave for control.
`timescale 1ns/1ps
`default_nettype none
module cpcm_unit
    import cpcm_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Instruction issue
    input wire cpcm_instr_type instr,
    // Second coprocessor
    output cpcm_cp2_type cp2_q,
    input wire logic [31:0] cp2_rdata,
    // Results
    output logic [31:0] gpr_wdata_q,
    output logic gpr_we_q,
    output cpcm_exc_type exc_q,
    output logic [31:0] fpsw_out_q,
    output logic irq_q
);
    logic [31:0] fpsw_q, fpsw_d;
    logic [31:0] ret_pc_q;
    logic [CPCM_EV_W-1:0] stat_q, mask_q;
    logic [1:0] en_q;
    logic [31:0] rdata_q;
    logic wr_pend_q;
    logic [7:0] waddr_q;
    logic [31:0] tmp;
    logic is_fp, is_cp2, is_ct, is_cf, is_op, unusable, fp_ct, fp_trap;
    logic [CPCM_EV_W-1:0] ev;

    assign tmp = instr.gpr;
    assign is_fp = instr.word[31:26] == CPCM_OP_FP;
    assign is_cp2 = instr.word[31:26] == CPCM_OP_CP2;
    assign is_ct = instr.word[25:21] == CPCM_SUB_CT;
    assign is_cf = instr.word[25:21] == CPCM_SUB_CF;
    assign is_op = instr.word[25];
    // Unusable check covers every move and operation of the addressed unit
    assign unusable = instr.valid && ((is_fp && !en_q[0]) || (is_cp2 && !en_q[1])); // [RULE_12]
    assign fp_ct = instr.valid && is_fp && is_ct && en_q[0];

    // Partial views merge into the status word; other selectors leave it alone
    always_comb begin
        fpsw_d = fpsw_q;
        if (fp_ct) begin // [RULE_03]
            case (instr.word[15:11])
                CPCM_SEL_CC: fpsw_d = {tmp[7:1], fpsw_q[24], tmp[0], fpsw_q[22:0]}; // [RULE_04]
                CPCM_SEL_EX: fpsw_d = {fpsw_q[31:18], tmp[17:12], fpsw_q[11:7],
                                       tmp[6:2], fpsw_q[1:0]}; // [RULE_05]
                CPCM_SEL_EN: fpsw_d = {fpsw_q[31:25], tmp[2], fpsw_q[23:12], tmp[11:7],
                                       fpsw_q[6:2], tmp[1:0]}; // [RULE_06]
                CPCM_SEL_CS: fpsw_d = tmp; // [RULE_07]
                default: fpsw_d = fpsw_q;
            endcase
        end
    end

    // Unimplemented cause bit 17 always traps; others need their enable
    assign fp_trap = fp_ct && (fpsw_d[17] || |(fpsw_d[16:12] & fpsw_d[11:7])); // [RULE_08]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fpsw_q <= CPCM_FPSW_RESET;
        end else if (wr_pend_q && waddr_q == CPCM_A_FPSW) begin
            fpsw_q <= hwdata;
        end else begin
            fpsw_q <= fpsw_d; // [RULE_08]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            exc_q <= '0;
            ret_pc_q <= '0;
        end else begin
            exc_q.valid <= unusable || fp_trap;
            exc_q.fp_exc <= fp_trap;
            exc_q.unusable <= unusable;
            exc_q.unit <= is_fp ? CPCM_UNIT_FP : CPCM_UNIT_CP2;
            exc_q.return_pc <= instr.pc; // [RULE_09]
            if (unusable || fp_trap) begin
                ret_pc_q <= instr.pc; // [RULE_09]
            end
        end
    end

    // Dispatch to second coprocessor; it owns its side effects
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cp2_q <= '0;
        end else begin
            cp2_q.op_valid <= instr.valid && is_cp2 && is_op && en_q[1]; // [RULE_02]
            cp2_q.ct_valid <= instr.valid && is_cp2 && !is_op && is_ct && en_q[1]; // [RULE_11]
            cp2_q.cf_valid <= instr.valid && is_cp2 && !is_op && is_cf && en_q[1];
            cp2_q.cofun <= instr.word[24:0]; // [RULE_01]
            cp2_q.sel <= instr.word[15:0]; // [RULE_11]
            cp2_q.data <= tmp;
        end
    end

    // Read-back from the coprocessor lands one cycle after the request
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gpr_we_q <= 1'b0;
            gpr_wdata_q <= '0;
        end else begin
            gpr_we_q <= cp2_q.cf_valid;
            gpr_wdata_q <= cp2_rdata;
        end
    end

    assign ev[CPCM_EV_FPE] = fp_trap;
    assign ev[CPCM_EV_CPU] = unusable;
    assign ev[CPCM_EV_CP2] = cp2_q.op_valid;

    // Set beats a simultaneous clear so no event is lost
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_q <= '0;
        end else if (wr_pend_q && waddr_q == CPCM_A_STATUS) begin
            stat_q <= (stat_q & ~hwdata[CPCM_EV_W-1:0]) | ev;
        end else begin
            stat_q <= stat_q | ev;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_q <= '0;
            en_q <= '0;
        end else if (wr_pend_q) begin
            if (waddr_q == CPCM_A_MASK) begin
                mask_q <= hwdata[CPCM_EV_W-1:0];
            end
            if (waddr_q == CPCM_A_ENABLE) begin
                en_q <= hwdata[1:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_q <= 1'b0;
            fpsw_out_q <= CPCM_FPSW_RESET;
        end else begin
            irq_q <= |(stat_q & mask_q);
            fpsw_out_q <= fpsw_q;
        end
    end

    // AHB address phase capture; zero-wait slave
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            waddr_q <= '0;
            rdata_q <= '0;
        end else begin
            wr_pend_q <= hsel && hready && htrans[1] && hwrite;
            waddr_q <= haddr[7:0];
            if (hsel && hready && htrans[1] && !hwrite) begin
                case (haddr[7:0])
                    CPCM_A_STATUS: rdata_q <= {{(32-CPCM_EV_W){1'b0}}, stat_q};
                    CPCM_A_MASK: rdata_q <= {{(32-CPCM_EV_W){1'b0}}, mask_q};
                    CPCM_A_ENABLE: rdata_q <= {30'h0, en_q};
                    CPCM_A_FPSW: rdata_q <= fpsw_q;
                    CPCM_A_RETPC: rdata_q <= ret_pc_q;
                    default: rdata_q <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    assign hrdata = rdata_q;
    // Selectors outside 25/26/28/31 leave the word as it was [RULE_10]
endmodule
`default_nettype wire

// ==== tb/cpcm_unit_asserts.sv ====
// Port timing checks of the coprocessor control move unit.
// Assumes a bind to cpcm_unit; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module cpcm_unit_asserts
    import cpcm_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Watched ports
    input wire cpcm_instr_type instr,
    input wire cpcm_cp2_type cp2_q,
    input wire logic [31:0] cp2_rdata,
    input wire logic [31:0] gpr_wdata_q,
    input wire logic gpr_we_q,
    input wire cpcm_exc_type exc_q,
    input wire logic [31:0] fpsw_out_q
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_word_move;
        instr.valid && instr.word[31:21] == 11'h226 && instr.word[15:11] == CPCM_SEL_CS;
    endsequence
    a_cofun_pass: assert property (
        cp2_q.op_valid |-> cp2_q.cofun == $past(instr.word[24:0])) else $error("cofun differs");
    a_op_source: assert property (cp2_q.op_valid |-> $past(instr.word[31:25]) == 7'h25)
        else $error("op without op word");
    a_ct_word: assert property (cp2_q.ct_valid |-> cp2_q.data == $past(instr.gpr)
        && cp2_q.sel == $past(instr.word[15:0])) else $error("cp2 move word");
    a_read_back: assert property (
        cp2_q.cf_valid |=> gpr_we_q && gpr_wdata_q == $past(cp2_rdata)) else $error("readback wrong");
    a_unusable_abort: assert property (exc_q.unusable |-> !(cp2_q.ct_valid || cp2_q.op_valid))
        else $error("transfer despite unusable");
    a_return_pc: assert property (exc_q.valid |-> exc_q.return_pc == $past(instr.pc))
        else $error("return pc wrong");
    a_trap_cause: assert property (exc_q.fp_exc |=> fpsw_out_q[17]
        || |(fpsw_out_q[16:12] & fpsw_out_q[11:7])) else $error("trap without cause");
    a_word_write: assert property (s_word_move ##1 !exc_q.unusable
        |=> fpsw_out_q == $past(instr.gpr, 2)) else $error("status word not written");
endmodule
`default_nettype wire

// ==== tb/cpcm_cp2_model.sv ====
// Behavioural second coprocessor: control registers and operation log.
// Assumes requests from cpcm_unit sampled on hclk.
`timescale 1ns/1ps
`default_nettype none
module cpcm_cp2_model
    import cpcm_pkg::*;
(
    // Clock and request
    input wire logic hclk,
    input wire cpcm_cp2_type cp2,
    // Answers
    output logic [31:0] rdata,
    output logic [24:0] last_cofun
);
    logic [31:0] regs [16];
    // Selector meaning is ours: low four bits pick a register
    always @(posedge hclk) begin
        if (cp2.ct_valid) begin
            regs[cp2.sel[3:0]] <= cp2.data;
        end
        // Operation changes only coprocessor state
        if (cp2.op_valid) begin
            last_cofun <= cp2.cofun;
        end
    end
    // Outside a read the lines show the inverse, so stale data cannot pass
    assign rdata = cp2.cf_valid ? regs[cp2.sel[3:0]] : ~regs[cp2.sel[3:0]];
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Bench: AHB-Lite register access and instruction issue with checks.
// Assumes cpcm_unit, its checker and the second coprocessor model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import cpcm_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp, gpr_we_q, irq_q;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, cp2_rdata, gpr_wdata_q, fpsw_out_q, e, r;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [24:0] cofun;
    cpcm_instr_type instr = '0;
    cpcm_cp2_type cp2_q;
    cpcm_exc_type exc_q;
    int error_cnt = 0, compares = 0;
    logic [4:0] sel [5] = '{5'h1F, 5'h19, 5'h1C, 5'h1A, 5'h1C};
    logic [31:0] src [5] = '{32'h0100_0F83, 32'hA5, 32'h4, 32'h107C, 32'h80};
    always #20 hclk = ~hclk;
    assign hready = hreadyout;
    cpcm_unit cpcm_unit_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .instr, .cp2_q, .cp2_rdata, .gpr_wdata_q,
        .gpr_we_q, .exc_q, .fpsw_out_q, .irq_q);
    cpcm_cp2_model cpcm_cp2_model_i (.hclk, .cp2(cp2_q), .rdata(cp2_rdata), .last_cofun(cofun));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        if (error_cnt == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic hwait;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            error_cnt++;
            give_verdict();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        hwait();
        hsel <= 0;
        htrans <= 0;
        hwdata <= d;
        hwait();
        r = hrdata;
    endtask
    // One-cycle issue; results are sampled once the taking edge has landed
    task automatic iss(input logic [31:0] w, input logic [31:0] g);
        @(posedge hclk);
        instr <= '{1'b1, w, 32'h400, g};
        @(posedge hclk);
        instr.valid <= 0;
        #1;
    endtask
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1;
        iss({11'h226, 10'h1F, 11'h0}, 32'h1);
        chk(32'({exc_q.unusable, exc_q.unit}), 32'({1'b1, CPCM_UNIT_FP}));
        bus(0, CPCM_A_STATUS, 0);
        chk(r, 32'h2);
        chk(32'({hreadyout, hresp}), 32'h2);
        bus(1, CPCM_A_STATUS, 32'h2);
        bus(1, CPCM_A_ENABLE, 32'h3);
        bus(1, CPCM_A_MASK, 32'h1);
        e = CPCM_FPSW_RESET;
        for (int i = 0; i < 5; i++) begin
            iss({11'h226, 5'h0, sel[i], 11'h0}, src[i]);
            case (sel[i])
                CPCM_SEL_CC: e = {src[i][7:1], e[24], src[i][0], e[22:0]};
                CPCM_SEL_EX: e = {e[31:18], src[i][17:12], e[11:7], src[i][6:2], e[1:0]};
                CPCM_SEL_EN: e = {e[31:25], src[i][2], e[23:12], src[i][11:7],
                                  e[6:2], src[i][1:0]};
                default: e = src[i];
            endcase
            chk(32'(exc_q.fp_exc), 32'(e[17] | |(e[16:12] & e[11:7])));
            @(posedge hclk);
            #1;
            chk(fpsw_out_q, e);
        end
        chk(32'(irq_q), 32'h1);
        bus(0, CPCM_A_RETPC, 0);
        chk(r, 32'h400);
        bus(1, CPCM_A_STATUS, 32'h1);
        iss({11'h246, 5'h0, 16'h0005}, 32'hCAFE_1234);
        iss({11'h242, 5'h0, 16'h0005}, 32'h0);
        @(posedge hclk);
        #1;
        chk(gpr_wdata_q, 32'hCAFE_1234);
        iss({7'h25, 25'h1ABCDEF}, 32'h0);
        @(posedge hclk);
        #1;
        chk(32'(cofun), 32'h1ABCDEF);
        chk(32'(irq_q), 32'h0);
        bus(0, CPCM_A_STATUS, 0);
        chk(r, 32'h4);
        bus(0, 8'h20, 0);
        chk(r, 32'h0);
        give_verdict();
    end
endmodule
bind cpcm_unit cpcm_unit_asserts cpcm_unit_asserts_i (.hclk, .hresetn, .instr, .cp2_q,
    .cp2_rdata, .gpr_wdata_q, .gpr_we_q, .exc_q, .fpsw_out_q);
`default_nettype wire
